// ### src/ftd_pkg.sv
// Purpose: shared constants and carriers for the 14-bit instruction decoder
// Assumes: one system clock; oscillator periods arrive as a one-cycle enable
// Notes:   field positions and opcode patterns live here only
package ftd_pkg;
    localparam int INSN_W      = 14;
    localparam int DATA_W      = 8;
    localparam int FADDR_W     = 7;
    localparam int BIT_W       = 3;
    localparam int LIT8_W      = 8;
    localparam int LIT11_W     = 11;
    localparam int PHASE_CNT   = 4;
    localparam int PH_W        = 2;
    localparam logic [PH_W-1:0] PH_READ  = 2'h1;
    localparam logic [PH_W-1:0] PH_LAST  = 2'h3;
    localparam logic [PH_W-1:0] PH_FIRST = 2'h0;
    // field positions
    localparam int CLS_HI      = 13;
    localparam int CLS_LO      = 12;
    localparam int DEST_POS    = 7;
    localparam int BIT_LO      = 7;
    localparam int BOP_HI      = 11;
    localparam int BOP_LO      = 10;
    localparam int BYOP_HI     = 11;
    localparam int BYOP_LO     = 8;
    localparam int JUMP_POS    = 11;
    localparam int JKIND_POS   = 11;
    localparam int LOP_HI      = 11;
    localparam int LOP_LO      = 8;
    localparam int LKIND_LO    = 10;
    // class codes
    localparam logic [1:0] CLS_BYTE  = 2'h0;
    localparam logic [1:0] CLS_BIT   = 2'h1;
    localparam logic [1:0] CLS_JUMP  = 2'h2;
    localparam logic [1:0] CLS_LIT   = 2'h3;
    // byte op codes
    localparam logic [3:0] BY_STORE  = 4'h0;
    localparam logic [3:0] BY_CLR    = 4'h1;
    localparam logic [3:0] BY_DECSZ  = 4'hb;
    localparam logic [3:0] BY_INCSZ  = 4'hf;
    // bit op codes
    localparam logic [1:0] BT_CLR    = 2'h0;
    localparam logic [1:0] BT_SET    = 2'h1;
    localparam logic [1:0] BT_SKC    = 2'h2;
    localparam logic [1:0] BT_SKS    = 2'h3;
    // literal op code for return-with-literal (bits 9:8 are don't-care)
    localparam logic [1:0] LIT_RETVAL = 2'h1;
    localparam logic [13:0] INSN_RETURN = 14'h0008;
    localparam logic [13:0] INSN_RETINT = 14'h0009;
    localparam logic [13:0] INSN_NOP    = 14'h0000;
    localparam logic [FADDR_W-1:0] TIMER_ADDR = 7'h01;
    localparam logic [FADDR_W-1:0] PORT_ADDR0 = 7'h05;
    localparam logic [FADDR_W-1:0] PORT_ADDR1 = 7'h06;

    typedef enum logic [1:0] {FTD_BYTE, FTD_BIT, FTD_CTRL} ftd_class_e;

    typedef struct packed {
        ftd_class_e               cls;
        logic                     toFile;
        logic [FADDR_W-1:0]       fileAddr;
        logic [BIT_W-1:0]         bitSel;
        logic [LIT11_W-1:0]       literal;
        logic                     longLit;
        logic                     fileOp;
        logic                     branch;
        logic                     skipTest;
    } ftd_dec_s;

    typedef struct packed {
        logic                     rdEn;
        logic                     wrEn;
        logic [FADDR_W-1:0]       addr;
        logic [DATA_W-1:0]        wrData;
        logic                     pinRead;
    } ftd_file_s;
endpackage : ftd_pkg

// ### src/ftd_decoder.sv
// Purpose: split 14-bit words into fields, time instruction cycles, drive file R-M-W
// Assumes: oscTick is one cycle per oscillator period; file read data valid same cycle
// Notes:   ALU result is supplied from outside; this block routes and sequences
module ftd_decoder
    import ftd_pkg::*;
(
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        oscTick,
    // program memory side
    input  wire logic [ftd_pkg::INSN_W-1:0]  insnWord,
    output logic                             fetchStrobe,
    // alu, accumulator, decoded fields and program counter
    input  wire logic [ftd_pkg::DATA_W-1:0]  aluResult,
    input  wire logic                        aluZero,
    output logic [ftd_pkg::DATA_W-1:0]       aluOperand,
    output ftd_pkg::ftd_dec_s                decoded,
    output logic                             accWrite,
    output logic [ftd_pkg::DATA_W-1:0]       accData,
    output logic                             pcLoad,
    output logic [ftd_pkg::LIT11_W-1:0]      pcTarget,
    // file register space
    input  wire logic [ftd_pkg::DATA_W-1:0]  fileRdData,
    input  wire logic [ftd_pkg::DATA_W-1:0]  portPinLevels,
    output ftd_pkg::ftd_file_s               fileBus,
    // timer zero
    input  wire logic                        prescalerOnTimer,
    output logic                             prescalerClear,
    // status
    output logic                             nopCycle,
    output logic [ftd_pkg::PH_W-1:0]         phase
);
    import ftd_pkg::*;

    typedef struct packed {
        logic [PH_W-1:0]    ph;
        logic [INSN_W-1:0]  ir;
        logic               flush;
        logic [DATA_W-1:0]  rdVal;
        logic               fetch;
        logic               accWr;
        logic [DATA_W-1:0]  accD;
        logic               pcLd;
        logic [LIT11_W-1:0] pcT;
        ftd_file_s          fb;
        logic               psClr;
        logic               rdSeen;
    } ftd_state_s;

    ftd_state_s s_q;
    ftd_state_s s_d;
    ftd_dec_s   dec;

    function automatic ftd_dec_s decode(input logic [INSN_W-1:0] w);
        ftd_dec_s r;
        r          = '0;
        r.fileAddr = w[FADDR_W-1:0];
        r.bitSel   = w[BIT_LO+BIT_W-1:BIT_LO];
        r.toFile   = w[DEST_POS];
        r.literal  = w[LIT11_W-1:0];
        case (w[CLS_HI:CLS_LO])
            CLS_BYTE: begin
                r.cls    = FTD_BYTE;
                r.fileOp = (w[BYOP_HI:BYOP_LO] != BY_STORE && w[BYOP_HI:BYOP_LO] != BY_CLR) || w[DEST_POS];
                if (w[BYOP_HI:BYOP_LO] == BY_STORE || w[BYOP_HI:BYOP_LO] == BY_CLR) begin
                    r.toFile = w[DEST_POS];
                end
                if (w == INSN_RETURN || w == INSN_RETINT) begin
                    r.cls    = FTD_CTRL;
                    r.branch = 1'b1;
                end
                r.skipTest = r.fileOp && (w[BYOP_HI:BYOP_LO] == BY_DECSZ || w[BYOP_HI:BYOP_LO] == BY_INCSZ);
            end
            CLS_BIT: begin
                r.cls      = FTD_BIT;
                r.fileOp   = 1'b1;
                r.toFile   = !w[BOP_HI];
                r.skipTest = w[BOP_HI];
            end
            CLS_JUMP: begin
                r.cls     = FTD_CTRL;
                r.longLit = 1'b1;
                r.branch  = 1'b1;
            end
            default: begin
                r.cls     = FTD_CTRL;
                r.literal = {{(LIT11_W-LIT8_W){1'b0}}, w[LIT8_W-1:0]};
                // bits 9:8 are never compared, so x positions decode alike
                r.branch  = (w[LOP_HI:LKIND_LO] == LIT_RETVAL);
            end
        endcase
        return r;
    endfunction : decode

    function automatic logic isPort(input logic [FADDR_W-1:0] a);
        return (a == PORT_ADDR0) || (a == PORT_ADDR1);
    endfunction : isPort

    assign dec = decode(s_q.ir);

    always_comb begin
        logic [DATA_W-1:0] rv;
        logic [DATA_W-1:0] res;
        logic              testTrue;
        logic              toAcc;
        rv       = '0;
        toAcc    = 1'b0;
        res      = '0;
        testTrue = 1'b0;
        s_d       = s_q;
        s_d.fetch = 1'b0;
        s_d.accWr = 1'b0;
        s_d.pcLd  = 1'b0;
        s_d.psClr = 1'b0;
        s_d.fb.rdEn = 1'b0;
        s_d.fb.wrEn = 1'b0;
        s_d.fb.pinRead = 1'b0;
        if (oscTick) begin
            // four oscillator periods per instruction cycle
            s_d.ph = (s_q.ph == PH_LAST) ? PH_FIRST : s_q.ph + 1'b1;
            if (s_q.ph == PH_READ && !s_q.flush && dec.fileOp) begin
                // read issued even for clear with d set: port side effects must happen
                s_d.fb.rdEn    = 1'b1;
                s_d.fb.addr    = dec.fileAddr;
                s_d.fb.pinRead = isPort(dec.fileAddr);
                s_d.rdSeen     = 1'b1;
            end
            if (s_q.ph == PH_LAST) begin
                s_d.fetch = 1'b1;
                s_d.ir    = insnWord;
                s_d.flush = 1'b0;
                s_d.rdSeen = 1'b0;
                if (!s_q.flush) begin
                    rv  = s_q.rdVal;
                    res = aluResult;
                    if (dec.cls == FTD_BIT) begin
                        res = rv;
                        res[dec.bitSel] = (s_q.ir[BOP_HI:BOP_LO] == BT_SET);
                        testTrue = (s_q.ir[BOP_HI:BOP_LO] == BT_SKC) ? !rv[dec.bitSel] :
                                   (s_q.ir[BOP_HI:BOP_LO] == BT_SKS) ? rv[dec.bitSel] : 1'b0;
                    end else if (dec.skipTest) begin
                        testTrue = aluZero;
                    end
                    // store-from-accumulator with d clear is the no-op and control group: no result
                    toAcc = (s_q.ir[CLS_HI:CLS_LO] == CLS_LIT) ||
                            (dec.cls == FTD_BYTE && !dec.toFile &&
                             (dec.fileOp || s_q.ir[BYOP_HI:BYOP_LO] != BY_STORE));
                    if (dec.fileOp && dec.toFile && !(dec.cls == FTD_BIT && dec.skipTest)) begin
                        s_d.fb.wrEn   = 1'b1;
                        s_d.fb.addr   = dec.fileAddr;
                        s_d.fb.wrData = res;
                        s_d.psClr     = (dec.fileAddr == TIMER_ADDR) && prescalerOnTimer;
                    end else if (toAcc) begin
                        s_d.accWr = 1'b1;
                        s_d.accD  = res;
                    end
                    if (dec.branch) begin
                        s_d.pcLd = dec.longLit;
                        s_d.pcT  = dec.literal;
                    end
                    // second cycle runs as a no-op on the discarded prefetch
                    s_d.flush = dec.branch || testTrue;
                    if (s_d.flush) begin
                        s_d.ir = INSN_NOP;
                    end
                end
            end
        end
        if (s_q.fb.rdEn) begin
            s_d.rdVal = s_q.fb.pinRead ? portPinLevels : fileRdData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q    <= '0;
            s_q.ph <= PH_FIRST;
        end else begin
            s_q <= s_d;
        end
    end

    assign fetchStrobe    = s_q.fetch;
    assign aluOperand     = s_q.rdVal;
    assign decoded        = dec;
    assign accWrite       = s_q.accWr;
    assign accData        = s_q.accD;
    assign pcLoad         = s_q.pcLd;
    assign pcTarget       = s_q.pcT;
    assign fileBus        = s_q.fb;
    assign prescalerClear = s_q.psClr;
    assign nopCycle       = s_q.flush;
    assign phase          = s_q.ph;

    property p_cycle_four;
        @(posedge clock) disable iff (rst)
        oscTick && s_q.ph == PH_LAST |=> s_q.ph == PH_FIRST;
    endproperty
    a_cycle_four: assert property (p_cycle_four) else $error("phase did not wrap after four periods");

    property p_flush_nowrite;
        @(posedge clock) disable iff (rst)
        s_q.flush && oscTick && s_q.ph == PH_LAST |=> !s_q.fb.wrEn && !s_q.accWr;
    endproperty
    a_flush_nowrite: assert property (p_flush_nowrite) else $error("discarded word had an effect");

    property p_read_before_write;
        @(posedge clock) disable iff (rst)
        oscTick && s_q.ph == PH_LAST && !s_q.flush && dec.fileOp |-> s_q.rdSeen;
    endproperty
    a_read_before_write: assert property (p_read_before_write) else $error("write without read");

    property p_psclr;
        @(posedge clock) disable iff (rst)
        s_q.psClr |-> s_q.fb.wrEn && s_q.fb.addr == TIMER_ADDR;
    endproperty
    a_psclr: assert property (p_psclr) else $error("prescaler clear without timer write");

    property p_flush_noread;
        @(posedge clock) disable iff (rst)
        s_q.flush |-> !s_q.fb.rdEn;
    endproperty
    a_flush_noread: assert property (p_flush_noread) else $error("discarded word issued a read");

    property p_one_destination;
        @(posedge clock) disable iff (rst)
        s_q.fb.wrEn |-> !s_q.accWr;
    endproperty
    a_one_destination: assert property (p_one_destination) else $error("result sent to both places");
endmodule : ftd_decoder

// ### tb/ftd_mem_model.sv
// Purpose: program memory and file space in front of the decoder
// Assumes: file data answers while the read strobe stands
// Notes:   between answers the data lines show the inverse of their last value
module ftd_mem_model
    import ftd_pkg::*;
(
    // clock
    input  wire logic                       clock,
    // program side
    input  wire logic                       armed,
    input  wire logic [ftd_pkg::INSN_W-1:0] nextWord,
    output logic [ftd_pkg::INSN_W-1:0]      insnWord,
    // file side
    input  wire ftd_pkg::ftd_file_s         fileBus,
    output logic [ftd_pkg::DATA_W-1:0]      fileRdData,
    output logic [ftd_pkg::DATA_W-1:0]      portPinLevels
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] idleData = 8'hff;
    logic [DATA_W-1:0] idlePins = 8'hff;
    // filler reads file 0x20 into the accumulator, so a discarded one shows up
    assign insnWord = armed ? nextWord : 14'h0820;
    // the decoder samples while its strobe stands, so answer then
    assign fileRdData    = fileBus.rdEn ? {1'b0, fileBus.addr} : idleData;
    // pins differ from the latch contents on purpose
    assign portPinLevels = fileBus.rdEn ? 8'ha5 : idlePins;
    // released lines show the inverse of the last answer
    always @(posedge clock) begin
        if (fileBus.rdEn) begin
            idleData <= ~{1'b0, fileBus.addr};
            idlePins <= 8'h5a;
        end
    end
endmodule : ftd_mem_model

// ### tb/fourteen_bit_instruction_decoder_test.sv
// Purpose: run single instructions between fillers and check what each one does
// Assumes: one oscillator tick every second clock; alu returns the complement
// Notes:   flags are {read, write, acc, pc, prescaler, no-op, filler read, pins}
module fourteen_bit_instruction_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ftd_pkg::*;
    logic                clock, rst, oscTick, aluZero, prescalerOnTimer, armed;
    logic                fetchStrobe, accWrite, pcLoad, prescalerClear, nopCycle;
    logic [INSN_W-1:0]   insnWord, nextWord;
    logic [DATA_W-1:0]   aluResult, aluOperand, accData, fileRdData, portPinLevels, data;
    logic [LIT11_W-1:0]  pcTarget, tgt;
    logic [PH_W-1:0]     phase;
    logic [FADDR_W-1:0]  addr;
    logic [7:0]          flg;
    bit                  seen;
    ftd_class_e          cls;
    ftd_dec_s            decoded;
    ftd_file_s           fileBus;
    int                  miscompares, comparisons, cnt, gap;

    ftd_decoder ftd_decoder_i (.clock(clock), .rst(rst), .oscTick(oscTick), .insnWord(insnWord),
        .fetchStrobe(fetchStrobe), .aluResult(aluResult), .aluZero(aluZero), .aluOperand(aluOperand),
        .decoded(decoded), .accWrite(accWrite), .accData(accData), .pcLoad(pcLoad), .pcTarget(pcTarget),
        .fileRdData(fileRdData), .portPinLevels(portPinLevels), .fileBus(fileBus),
        .prescalerOnTimer(prescalerOnTimer), .prescalerClear(prescalerClear), .nopCycle(nopCycle),
        .phase(phase));
    ftd_mem_model ftd_mem_model_i (.clock(clock), .armed(armed), .nextWord(nextWord), .insnWord(insnWord),
        .fileBus(fileBus), .fileRdData(fileRdData), .portPinLevels(portPinLevels));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // one word between fillers; ed[8] asks for the data value to be compared
    task automatic run(input logic [13:0] w, input logic z, input logic p, input ftd_class_e ec,
                       input logic [7:0] ef, input logic [6:0] ea, input logic [8:0] ed, input logic [10:0] et);
        @(negedge clock iff fetchStrobe);
        @(posedge clock);
        nextWord <= w;
        armed <= 1'b1;
        aluZero <= z;
        prescalerOnTimer <= p;
        cnt = 0;
        flg = 8'h00;
        addr = 7'h00;
        data = 8'h00;
        tgt = 11'h000;
        while (cnt < 1) @(posedge clock);
        armed <= 1'b0;
        while (cnt < 3) @(posedge clock);
        chk("class", 16'(ec), 16'(cls));
        chk("flags", 16'(ef), 16'(flg));
        chk("address", 16'(ea), 16'(addr));
        if (ed[8]) chk("data", 16'(ed[7:0]), 16'(data));
        chk("target", 16'(et), 16'(tgt));
    endtask : run

    // bucket port activity by fetches since the word under test was taken
    always @(negedge clock) begin
        gap = gap + 1;
        if (fetchStrobe) begin
            if (seen) chk("fetch spacing", 16'(2 * PHASE_CNT), 16'(gap));
            gap = 0;
            seen = 1'b1;
            cnt = cnt + 1;
            if (cnt == 1) cls = decoded.cls;
        end
        // the previous word's results land on the fetch edge of this one
        if ((cnt == 1 && !fetchStrobe) || (cnt == 2 && fetchStrobe)) begin
            if (fileBus.rdEn) flg[7] = 1'b1;
            if (fileBus.rdEn) addr = fileBus.addr;
            if (fileBus.rdEn) flg[0] = fileBus.pinRead;
            if (fileBus.wrEn) flg[6] = 1'b1;
            if (fileBus.wrEn) data = fileBus.wrData;
            if (accWrite) flg[5] = 1'b1;
            if (accWrite) data = accData;
            if (pcLoad) flg[4] = 1'b1;
            if (pcLoad) tgt = pcTarget;
            if (prescalerClear) flg[3] = 1'b1;
        end
        if (cnt == 2 && !fetchStrobe && nopCycle) flg[2] = 1'b1;
        if (cnt == 2 && !fetchStrobe && fileBus.rdEn) flg[1] = 1'b1;
    end

    // alu stand-in: complement of the operand, one clock behind
    always @(posedge clock) aluResult <= ~aluOperand;
    always @(posedge clock) oscTick <= rst ? 1'b0 : ~oscTick;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        repeat (6000) @(posedge clock);
        miscompares++;
        results();
    end

    initial begin
        {rst, aluZero, prescalerOnTimer, armed} = 4'b1000;
        nextWord = 14'h0000;
        repeat (8) @(posedge clock);
        chk("phase in reset", 16'h0000, 16'(phase));
        rst <= 1'b0;
        run(14'h09a5, 0, 0, FTD_BYTE, 8'b1100_0010, 7'h25, 9'h1da, 11'h000);
        run(14'h0925, 0, 0, FTD_BYTE, 8'b1010_0010, 7'h25, 9'h1da, 11'h000);
        run(14'h01ff, 0, 0, FTD_BYTE, 8'b1100_0010, 7'h7f, 9'h180, 11'h000);
        run(14'h0986, 0, 0, FTD_BYTE, 8'b1100_0011, 7'h06, 9'h15a, 11'h000);
        run(14'h0081, 0, 1, FTD_BYTE, 8'b1100_1010, 7'h01, 9'h000, 11'h000);
        run(14'h0081, 0, 0, FTD_BYTE, 8'b1100_0010, 7'h01, 9'h000, 11'h000);
        run(14'h1bb0, 1, 0, FTD_BIT, 8'b1000_0100, 7'h30, 9'h000, 11'h000);
        run(14'h1fb0, 1, 0, FTD_BIT, 8'b1000_0010, 7'h30, 9'h000, 11'h000);
        run(14'h0ba0, 1, 0, FTD_BYTE, 8'b1100_0100, 7'h20, 9'h1df, 11'h000);
        run(14'h0ba0, 0, 0, FTD_BYTE, 8'b1100_0010, 7'h20, 9'h1df, 11'h000);
        run(14'h2da5, 0, 0, FTD_CTRL, 8'b0001_0100, 7'h00, 9'h000, 11'h5a5);
        run(14'h22ff, 0, 0, FTD_CTRL, 8'b0001_0100, 7'h00, 9'h000, 11'h2ff);
        run(14'h3455, 0, 0, FTD_CTRL, 8'b0010_0100, 7'h00, 9'h000, 11'h000);
        run(14'h3755, 0, 0, FTD_CTRL, 8'b0010_0100, 7'h00, 9'h000, 11'h000);
        run(14'h0008, 0, 0, FTD_CTRL, 8'b0000_0100, 7'h00, 9'h000, 11'h000);
        run(14'h0060, 0, 0, FTD_BYTE, 8'b0000_0010, 7'h00, 9'h000, 11'h000);
        run(14'h0100, 0, 0, FTD_BYTE, 8'b0010_0010, 7'h00, 9'h000, 11'h000);
        results();
    end
endmodule : fourteen_bit_instruction_decoder_test
